// [design/dtmu_defs.vh]
`ifndef DTMU_DEFS_VH
`define DTMU_DEFS_VH

// Register offsets on the plain register port (word index addresses).
`define DTMU_ADDR_W 4
`define DTMU_OFF_CTRL 4'h0
`define DTMU_OFF_S0 4'h1
`define DTMU_OFF_E0 4'h2
`define DTMU_OFF_S1 4'h3
`define DTMU_OFF_E1 4'h4
`define DTMU_OFF_MODE 4'h5
`define DTMU_OFF_STAT 4'h6

// Control register fields.
`define DTMU_SEL0_HI 31
`define DTMU_SEL0_LO 30
`define DTMU_SEL1_HI 29
`define DTMU_SEL1_LO 28
`define DTMU_SID1_HI 19
`define DTMU_SID1_LO 12
`define DTMU_SID1_EN 11
`define DTMU_SID0_HI 10
`define DTMU_SID0_LO 3
`define DTMU_SID0_EN 2
`define DTMU_WP1 1
`define DTMU_WP0 0
`define DTMU_CTRL_MASK 32'hf00fffff
`define DTMU_SEL_RD 0
`define DTMU_SEL_WR 1

// Mode register fields: data trace enable and event-in action.
`define DTMU_MODE_TRACE 1
`define DTMU_MODE_EVSYNC 2
`define DTMU_MODE_MASK 32'h00000006

// Transfer codes.
`define DTMU_TC_WR 6'h05
`define DTMU_TC_RD 6'h06
`define DTMU_TC_ERR 6'h08
`define DTMU_TC_WRS 6'h0d
`define DTMU_TC_RDS 6'h0e
`define DTMU_TC_WATCH 6'h3e
`define DTMU_ECODE_OVR 5'h02

// Size codes.
`define DTMU_SZ_8 2'h0
`define DTMU_SZ_16 2'h1
`define DTMU_SZ_32 2'h2

// Periodic sync counter terminal value (compressed messages since last sync).
`define DTMU_PER_MAX 8'hff

`endif

// [design/dtmu_top.v]
// How it works
// - Matching write emits compressed message, code 5.
// - Matching read emits compressed message, code 6.
// - Data field width follows access size.
// - Size code: 00 byte, 01 half, 10 word.
// - Address field XORs against previous trace message address.
// - Pending sync makes write use code 13.
// - Pending sync makes read use code 14.
// - First match after reset uses sync.
// - Turning trace on forces next sync.
// - Leaving power-down forces next sync.
// - Event-in with sync action forces sync.
// - Overrun emits error code 8 before sync.
// - 255 compressed messages force next sync.
// - Leaving debug mode forces next sync.
// - Two-bit per-channel read/write trace selectors.
// - Channel 1 optional space identifier match.
// - Channel 0 optional space identifier match.
// - Control bits 1,0 enable channel watchpoints.
// - Inclusive start-to-end range match per channel.
// - Start above end never matches.
// - Two channels, own start/end registers.
// - Trace messages only while trace mode bit set; watchpoint messages regardless.
// - Watch-enabled channel match emits watchpoint message when the access is not traced.
`timescale 1ns/1ps
`default_nettype none
`include "dtmu_defs.vh"

module dtmu_top (
  // Clock and reset.
  input wire clk_i,
  input wire rst_n_i,
  // Register port.
  input wire [`DTMU_ADDR_W-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Core data access observation.
  input wire acc_valid_i,
  input wire acc_write_i,
  input wire [1:0] acc_size_i,
  input wire [31:0] acc_addr_i,
  input wire [31:0] acc_data_i,
  input wire [7:0] acc_space_id_i,
  // Core state and pins.
  input wire debug_exit_i,
  input wire power_exit_i,
  input wire event_in_pin_i,
  input wire overrun_i,
  input wire watch_trace_on_i,
  input wire watch_trace_off_i,
  // Message output toward the auxiliary port.
  output reg msg_valid_o,
  output reg [5:0] msg_tcode_o,
  output reg [1:0] msg_size_code_o,
  output reg [31:0] msg_addr_o,
  output reg [31:0] msg_data_o,
  output reg [4:0] msg_ecode_o,
  output reg [1:0] msg_watch_hit_o
);

  reg [31:0] ctrl_reg;
  reg [31:0] s0_reg;
  reg [31:0] e0_reg;
  reg [31:0] s1_reg;
  reg [31:0] e1_reg;
  reg trace_on_reg;
  reg ev_sync_reg;
  reg sync_pend_reg;
  reg ovr_pend_reg;
  reg [7:0] per_cnt_reg;
  reg [31:0] ref_addr_reg;
  reg ev_m_reg;
  reg ev_s_reg;
  reg ev_d_reg;
  reg wr_hold_reg;
  reg [31:0] hold_addr_reg;
  reg [31:0] hold_data_reg;
  reg [1:0] hold_size_reg;
  reg hold_write_reg;
  reg [1:0] hold_watch_reg;

  wire [1:0] sel0 = ctrl_reg[`DTMU_SEL0_HI:`DTMU_SEL0_LO];
  wire [1:0] sel1 = ctrl_reg[`DTMU_SEL1_HI:`DTMU_SEL1_LO];

  // Inclusive range; start above end leaves the range empty.
  wire in0 = (acc_addr_i >= s0_reg) && (acc_addr_i <= e0_reg);
  wire in1 = (acc_addr_i >= s1_reg) && (acc_addr_i <= e1_reg);
  wire sid0_ok = !ctrl_reg[`DTMU_SID0_EN] ||
    (acc_space_id_i == ctrl_reg[`DTMU_SID0_HI:`DTMU_SID0_LO]);
  wire sid1_ok = !ctrl_reg[`DTMU_SID1_EN] ||
    (acc_space_id_i == ctrl_reg[`DTMU_SID1_HI:`DTMU_SID1_LO]);
  wire hit0 = acc_valid_i && in0 && sid0_ok;
  wire hit1 = acc_valid_i && in1 && sid1_ok;
  wire tr0 = hit0 && (acc_write_i ? sel0[`DTMU_SEL_WR] : sel0[`DTMU_SEL_RD]);
  wire tr1 = hit1 && (acc_write_i ? sel1[`DTMU_SEL_WR] : sel1[`DTMU_SEL_RD]);
  wire trace_hit = trace_on_reg && (tr0 || tr1);
  wire [1:0] watch_hit = {hit1 && ctrl_reg[`DTMU_WP1], hit0 && ctrl_reg[`DTMU_WP0]};

  // Sync is taken when pending, on overrun, on debug or power-down exit, or when the periodic count is spent.
  wire ev_rise = ev_s_reg && !ev_d_reg;
  wire use_sync = sync_pend_reg || ovr_pend_reg || (per_cnt_reg == `DTMU_PER_MAX) ||
    debug_exit_i || power_exit_i;

  // Event-in pin synchroniser.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ev_m_reg <= 1'b0;
      ev_s_reg <= 1'b0;
      ev_d_reg <= 1'b0;
    end else begin
      ev_m_reg <= event_in_pin_i;
      ev_s_reg <= ev_m_reg;
      ev_d_reg <= ev_s_reg;
    end
  end

  // Register writes and trace enable handling.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= 32'h00000000;
      s0_reg <= 32'h00000000;
      e0_reg <= 32'h00000000;
      s1_reg <= 32'h00000000;
      e1_reg <= 32'h00000000;
      trace_on_reg <= 1'b0;
      ev_sync_reg <= 1'b0;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `DTMU_OFF_CTRL: ctrl_reg <= reg_wdata_i & `DTMU_CTRL_MASK;
          `DTMU_OFF_S0: s0_reg <= reg_wdata_i;
          `DTMU_OFF_E0: e0_reg <= reg_wdata_i;
          `DTMU_OFF_S1: s1_reg <= reg_wdata_i;
          `DTMU_OFF_E1: e1_reg <= reg_wdata_i;
          `DTMU_OFF_MODE: begin
            trace_on_reg <= reg_wdata_i[`DTMU_MODE_TRACE];
            ev_sync_reg <= reg_wdata_i[`DTMU_MODE_EVSYNC];
          end
          default: ;
        endcase
      end
      // A watchpoint may switch trace on or off; it wins over a register write.
      if (watch_trace_on_i) begin
        trace_on_reg <= 1'b1;
      end else if (watch_trace_off_i) begin
        trace_on_reg <= 1'b0;
      end
    end
  end

  wire trace_turn_on = !trace_on_reg && (watch_trace_on_i ||
    (reg_wr_i && (reg_addr_i == `DTMU_OFF_MODE) && reg_wdata_i[`DTMU_MODE_TRACE]));

  // Sync and overrun bookkeeping; new causes win over the clear of a sent sync.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_pend_reg <= 1'b1;
      ovr_pend_reg <= 1'b0;
      per_cnt_reg <= 8'h00;
      ref_addr_reg <= 32'h00000000;
    end else begin
      if (trace_hit) begin
        if (use_sync) begin
          sync_pend_reg <= 1'b0;
          ovr_pend_reg <= 1'b0;
          per_cnt_reg <= 8'h00;
        end else begin
          per_cnt_reg <= per_cnt_reg + 8'h01;
        end
        ref_addr_reg <= acc_addr_i;
      end
      if (trace_turn_on || (debug_exit_i && !trace_hit) || (power_exit_i && !trace_hit)) begin
        sync_pend_reg <= 1'b1;
      end
      if (ev_rise && ev_sync_reg) begin
        sync_pend_reg <= 1'b1;
      end
      if (overrun_i) begin
        ovr_pend_reg <= 1'b1;
      end
    end
  end

  // Message generator; an overrun sync is preceded by an error message.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      msg_valid_o <= 1'b0;
      msg_tcode_o <= 6'h00;
      msg_size_code_o <= 2'h0;
      msg_addr_o <= 32'h00000000;
      msg_data_o <= 32'h00000000;
      msg_ecode_o <= 5'h00;
      msg_watch_hit_o <= 2'h0;
      wr_hold_reg <= 1'b0;
      hold_addr_reg <= 32'h00000000;
      hold_data_reg <= 32'h00000000;
      hold_size_reg <= 2'h0;
      hold_write_reg <= 1'b0;
      hold_watch_reg <= 2'h0;
    end else begin
      msg_valid_o <= 1'b0;
      msg_ecode_o <= 5'h00;
      msg_watch_hit_o <= 2'h0;
      wr_hold_reg <= 1'b0;
      if (wr_hold_reg) begin
        // Deferred sync message that follows the error message.
        msg_valid_o <= 1'b1;
        msg_tcode_o <= hold_write_reg ? `DTMU_TC_WRS : `DTMU_TC_RDS;
        msg_addr_o <= hold_addr_reg;
        msg_data_o <= hold_data_reg;
        msg_size_code_o <= hold_size_reg;
        msg_watch_hit_o <= hold_watch_reg;
      end else if (trace_hit && ovr_pend_reg) begin
        msg_valid_o <= 1'b1;
        msg_tcode_o <= `DTMU_TC_ERR;
        msg_ecode_o <= `DTMU_ECODE_OVR;
        wr_hold_reg <= 1'b1;
        hold_write_reg <= acc_write_i;
        hold_addr_reg <= acc_addr_i;
        hold_data_reg <= size_mask(acc_data_i, acc_size_i);
        hold_size_reg <= acc_size_i;
        hold_watch_reg <= watch_hit;
      end else if (trace_hit) begin
        msg_valid_o <= 1'b1;
        msg_watch_hit_o <= watch_hit;
        msg_size_code_o <= acc_size_i;
        msg_data_o <= size_mask(acc_data_i, acc_size_i);
        if (use_sync) begin
          msg_tcode_o <= acc_write_i ? `DTMU_TC_WRS : `DTMU_TC_RDS;
          msg_addr_o <= acc_addr_i;
        end else begin
          msg_tcode_o <= acc_write_i ? `DTMU_TC_WR : `DTMU_TC_RD;
          msg_addr_o <= acc_addr_i ^ ref_addr_reg;
        end
      end else if (|watch_hit) begin
        msg_valid_o <= 1'b1;
        msg_tcode_o <= `DTMU_TC_WATCH;
        msg_watch_hit_o <= watch_hit;
        msg_addr_o <= acc_addr_i;
        msg_data_o <= 32'h00000000;
        msg_size_code_o <= acc_size_i;
      end
    end
  end

  // Keep only the bytes of the traced access width.
  function [31:0] size_mask;
    input [31:0] d;
    input [1:0] sz;
    begin
      case (sz)
        `DTMU_SZ_8: size_mask = {24'h000000, d[7:0]};
        `DTMU_SZ_16: size_mask = {16'h0000, d[15:0]};
        default: size_mask = d;
      endcase
    end
  endfunction

  // Read data one cycle after the read strobe.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `DTMU_OFF_CTRL: reg_rdata_o <= ctrl_reg;
        `DTMU_OFF_S0: reg_rdata_o <= s0_reg;
        `DTMU_OFF_E0: reg_rdata_o <= e0_reg;
        `DTMU_OFF_S1: reg_rdata_o <= s1_reg;
        `DTMU_OFF_E1: reg_rdata_o <= e1_reg;
        `DTMU_OFF_MODE: reg_rdata_o <= {29'h00000000, ev_sync_reg, trace_on_reg, 1'b0};
        `DTMU_OFF_STAT: reg_rdata_o <= {22'h000000, per_cnt_reg, ovr_pend_reg, sync_pend_reg};
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end
  end

endmodule // dtmu_top

`default_nettype wire

// [tb/dtmu_tool_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dtmu_tool_model (
  // Message stream.
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [5:0] tcode_i,
  input wire logic [1:0] size_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] data_i,
  input wire logic [4:0] ecode_i,
  input wire logic [1:0] hit_i,
  // Decoded view of recent messages.
  output var logic [5:0] tc_o = 6'h00,
  output var logic [5:0] ptc_o = 6'h00,
  output var logic [1:0] sz_o = 2'h0,
  output var logic [31:0] full_o = 32'h0,
  output var logic [31:0] dat_o = 32'h0,
  output var logic [4:0] ec_o = 5'h00,
  output var logic [1:0] hit_o = 2'h0,
  output var logic [15:0] cnt_o = 16'h0
);
  // The tool rebuilds full addresses from compressed ones.
  always @(posedge clk_i) begin
    if (valid_i) begin
      ptc_o <= tc_o;
      tc_o <= tcode_i;
      cnt_o <= cnt_o + 16'h1;
      hit_o <= hit_i;
      if (tcode_i == 6'h08) begin
        ec_o <= ecode_i;
      end else begin
        dat_o <= data_i;
        sz_o <= size_i;
      end
      if (tcode_i == 6'h0d || tcode_i == 6'h0e) begin
        full_o <= addr_i;
      end else if (tcode_i == 6'h05 || tcode_i == 6'h06) begin
        full_o <= full_o ^ addr_i;
      end
    end
  end
endmodule // dtmu_tool_model
`default_nettype wire

// [tb/dtmu_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module dtmu_top_props (
  // Watched ports.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [31:0] acc_addr_i,
  input wire logic msg_valid_o,
  input wire logic [5:0] msg_tcode_o,
  input wire logic [1:0] msg_size_code_o,
  input wire logic [31:0] msg_addr_o,
  input wire logic [31:0] msg_data_o,
  input wire logic [4:0] msg_ecode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic err_reg;
  logic [31:0] ref_reg;
  wire trc = msg_valid_o && msg_tcode_o inside {6'h05, 6'h06, 6'h0d, 6'h0e};
  wire syn = msg_valid_o && msg_tcode_o inside {6'h0d, 6'h0e};
  // Tracks the full address of the last trace message, as the tool would.
  always @(posedge clk_i) begin
    err_reg <= rst_n_i && msg_valid_o && msg_tcode_o == 6'h08;
    if (!rst_n_i) begin
      ref_reg <= 32'h0;
    end else if (syn) begin
      ref_reg <= msg_addr_o;
    end else if (trc) begin
      ref_reg <= msg_addr_o ^ ref_reg;
    end
  end
  a_size_code: assert property (trc |-> msg_size_code_o != 2'h3)
    else $error("size code out of range");
  a_narrow_data: assert property (trc && msg_size_code_o == 2'h0 |-> msg_data_o[31:8] == 24'h0)
    else $error("byte message data too wide");
  a_err_then_sync: assert property (msg_valid_o && msg_tcode_o == 6'h08 |-> msg_ecode_o == 5'h02 ##1 syn)
    else $error("error message not followed by sync");
  a_msg_cause: assert property (msg_valid_o |-> $past(acc_valid_i) || err_reg)
    else $error("message without access");
  a_sync_addr: assert property (syn && !err_reg |-> msg_addr_o == $past(acc_addr_i))
    else $error("sync address not full");
  a_comp_addr: assert property (trc && !syn |-> msg_addr_o == ($past(acc_addr_i) ^ ref_reg))
    else $error("compressed address wrong");
  a_write_kind: assert property (msg_valid_o && msg_tcode_o inside {6'h05, 6'h0d} && !err_reg
    |-> $past(acc_write_i))
    else $error("write code on read");
  a_read_kind: assert property (msg_valid_o && msg_tcode_o inside {6'h06, 6'h0e} && !err_reg
    |-> !$past(acc_write_i))
    else $error("read code on write");
  c_sync: cover property (syn);
  c_error: cover property (err_reg);
  c_watch: cover property (msg_valid_o && msg_tcode_o == 6'h3e);
endmodule // dtmu_top_props
`default_nettype wire

// [tb/dtmu_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module dtmu_top_test;
  logic clk_i = 0, rst_n_i = 0, rwr = 0, rrd = 0, av = 0, aw = 0;
  logic dx = 0, px = 0, ev = 0, ov = 0, won = 0, woff = 0;
  logic [3:0] ra = 0;
  logic [31:0] rw = 0, aa = 0, ad = 0;
  logic [1:0] asz = 0;
  logic [7:0] as = 0;
  logic [15:0] c0;
  wire [31:0] rdata, maddr, mdata, full, dat;
  wire mv;
  wire [5:0] mtc, tc, ptc;
  wire [1:0] msz, mhit, sz, hit;
  wire [4:0] mec, ec;
  wire [15:0] cnt;
  int n_errors = 0, n_tests = 0, cyc = 0, i;
  always #5 clk_i = ~clk_i;
  dtmu_top i_dtmu_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(ra), .reg_wdata_i(rw),
    .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata), .acc_valid_i(av), .acc_write_i(aw),
    .acc_size_i(asz), .acc_addr_i(aa), .acc_data_i(ad), .acc_space_id_i(as),
    .debug_exit_i(dx), .power_exit_i(px), .event_in_pin_i(ev), .overrun_i(ov),
    .watch_trace_on_i(won), .watch_trace_off_i(woff), .msg_valid_o(mv), .msg_tcode_o(mtc),
    .msg_size_code_o(msz), .msg_addr_o(maddr), .msg_data_o(mdata), .msg_ecode_o(mec),
    .msg_watch_hit_o(mhit));
  dtmu_tool_model i_dtmu_tool_model (.clk_i(clk_i), .valid_i(mv), .tcode_i(mtc), .size_i(msz),
    .addr_i(maddr), .data_i(mdata), .ecode_i(mec), .hit_i(mhit), .tc_o(tc), .ptc_o(ptc),
    .sz_o(sz), .full_o(full), .dat_o(dat), .ec_o(ec), .hit_o(hit), .cnt_o(cnt));
  task test_done;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clk_i);
    ra <= a;
    rw <= d;
    rwr <= 1'b1;
    @(posedge clk_i);
    rwr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [31:0] e);
    @(posedge clk_i);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk_i);
    rrd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  task acc(input w, input [1:0] s, input [31:0] a, input [31:0] d);
    c0 = cnt;
    @(posedge clk_i);
    av <= 1'b1;
    aw <= w;
    asz <= s;
    aa <= a;
    ad <= d;
    @(posedge clk_i);
    av <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task msg(input [5:0] t, input [31:0] a);
    `CHK("tcode", t, tc)
    `CHK("addr", a, full)
  endtask
  task none;
    `CHK("count", c0, cnt)
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(0, 0);
    wr(0, 32'hffffffff);
    rd(0, 32'hf00fffff);
    rd(7, 0);
    wr(1, 'h100);
    wr(2, 'h1ff);
    wr(3, 'h300);
    wr(4, 'h300);
    rd(2, 'h1ff);
    wr(0, 32'hd005a800);
    wr(5, 6);
    as <= 8'h5a;
    acc(1, 0, 'h104, 'h1ab); msg(6'h0d, 'h104);
    `CHK("data", 32'hab, dat)
    `CHK("size", 2'h0, sz)
    acc(0, 1, 'h1ff, 'h12345678); msg(6'h06, 'h1ff);
    `CHK("data", 32'h5678, dat)
    `CHK("size", 2'h1, sz)
    acc(1, 2, 'h100, 'h12345678); msg(6'h05, 'h100);
    `CHK("data", 32'h12345678, dat)
    `CHK("size", 2'h2, sz)
    acc(0, 2, 'h200, 0); none;
    acc(0, 2, 'h300, 0); msg(6'h06, 'h300);
    as <= 8'h11;
    acc(0, 2, 'h300, 0); none;
    as <= 8'h5a;
    acc(1, 2, 'h300, 0); none;
    for (i = 0; i < 4; i++) begin
      if (i == 3) wr(5, 0);
      wr(5, 6);
      dx <= i == 0;
      px <= i == 1;
      ev <= i == 2;
      @(posedge clk_i);
      dx <= 1'b0;
      px <= 1'b0;
      repeat (4) @(posedge clk_i);
      ev <= 1'b0;
      acc(1, 2, 'h108, 0); msg(6'h0d, 'h108);
      acc(1, 2, 'h10c, 0); msg(6'h05, 'h10c);
    end
    ov <= 1'b1;
    @(posedge clk_i);
    ov <= 1'b0;
    acc(0, 2, 'h110, 0); msg(6'h0e, 'h110);
    `CHK("prev", 6'h08, ptc)
    `CHK("ecode", 5'h02, ec)
    for (i = 1; i <= 256; i++) begin
      acc(0, 2, 'h100 + i % 256, 0); msg(i == 256 ? 6'h0e : 6'h06, 'h100 + i % 256);
    end
    wr(1, 'h200);
    wr(2, 'h100);
    acc(0, 2, 'h150, 0); none;
    wr(1, 'h100);
    wr(2, 'h1ff);
    wr(0, 32'h00000001);
    acc(1, 2, 'h120, 0); `CHK("tcode", 6'h3e, tc)
    `CHK("hit", 2'h1, hit)
    wr(0, 32'hc0000000);
    wr(5, 0);
    acc(1, 2, 'h120, 0); none;
    won <= 1'b1;
    @(posedge clk_i);
    won <= 1'b0;
    acc(1, 2, 'h124, 0); msg(6'h0d, 'h124);
    woff <= 1'b1;
    @(posedge clk_i);
    woff <= 1'b0;
    acc(1, 2, 'h128, 0); none;
    test_done;
  end
endmodule // dtmu_top_test
bind dtmu_top dtmu_top_props i_dtmu_top_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i),
  .msg_valid_o(msg_valid_o), .msg_tcode_o(msg_tcode_o), .msg_size_code_o(msg_size_code_o),
  .msg_addr_o(msg_addr_o), .msg_data_o(msg_data_o), .msg_ecode_o(msg_ecode_o));
`default_nettype wire
